// *** hw/brw_burst_read_wait.sv ***
/*
 * brw_burst_read_wait: device side of a synchronous burst read port.
 * Holds the link engine (address capture, wait states, burst order,
 * ready timing), the automatic sleep detector and the register file.
 * Assumes the host drives link_clk, the strobes and the address on that
 * clock, and that the storage array answers array_rdata combinationally
 * on link_clk from array_addr. Configuration changes only while idle.
 */
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - capture address first clock edge after strobe
// - initial latency programmable two to seven
// - extra delay near start, flagged on ready
// - wrap mode ascends and wraps inside group
// - no-wrap mode increments past group boundary
// - lead bit clear: ready one cycle early
// - sleep after stable address tACC plus 20ns
// - active edge rising only, falling setting refused at strobe
module brw_burst_read_wait
    import brw_pkg::*;
#(
    parameter int ADDR_W     = BRW_ADDR_W,
    parameter int DATA_W     = BRW_DATA_W,
    parameter int EXTRA_WAIT = BRW_EXTRA_WAIT
) (
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    // register port
    input  wire logic [BRW_REG_AW-1:0] reg_addr,
    input  wire logic [BRW_REG_DW-1:0] reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [BRW_REG_DW-1:0] reg_rdata,
    // link pins, on link_clk
    input  wire logic                  link_clk,
    input  wire brw_ctl_t              link_ctl,
    input  wire logic [ADDR_W-1:0]     link_addr,
    output logic      [DATA_W-1:0]     dq_o,
    output logic                       dq_oe,
    output logic                       ready_o,
    // storage array, on link_clk
    output logic      [ADDR_W-1:0]     array_addr,
    input  wire logic [DATA_W-1:0]     array_rdata,
    // low-power indication
    output logic                       sleep_o
);

    // ------------------------------------------------------------------
    // state types
    // ------------------------------------------------------------------
    localparam logic [2:0] EXTRA_CNT = 3'(EXTRA_WAIT);
    localparam logic [BRW_SLEEP_W-1:0] SLEEP_CNT = BRW_SLEEP_W'(BRW_SLEEP_CYCLES);

    // register-clock domain
    typedef struct packed {
        brw_cfg_t               cfg;
        logic                   busy_s1;
        logic                   busy_s2;
        logic                   refused_s1;
        logic                   refused_s2;
        logic [ADDR_W-1:0]      addr_s1;
        logic [ADDR_W-1:0]      addr_s2;
        logic [ADDR_W-1:0]      addr_prev;
        logic [BRW_SLEEP_W-1:0] stable_cnt;
        logic                   sleep;
        logic [BRW_REG_DW-1:0]  rdata;
    } brw_mstate_t;

    // link-clock domain
    typedef struct packed {
        logic              rst_s1;
        logic              rst_s2;
        brw_cfg_t          cfg_s1;
        brw_cfg_t          cfg_s2;
        brw_state_t        st;
        logic [2:0]        lat_cnt;
        logic [2:0]        extra_cnt;
        logic [2:0]        pos;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq;
        logic              dq_oe;
        logic              ready;
        logic              busy;
        logic              refused;
    } brw_lstate_t;

    brw_mstate_t m_ff;
    brw_mstate_t nxt_m;
    brw_lstate_t l_ff;
    brw_lstate_t nxt_l;

    // ------------------------------------------------------------------
    // register clock domain
    // ------------------------------------------------------------------

    // register file, link status synchronisers and sleep detector
    always_comb begin
        brw_cfg_t               wcfg;
        logic [BRW_REG_DW-1:0]  status;
        wcfg   = brw_cfg_t'(reg_wdata[BRW_CFG_W-1:0]);
        status = '0;
        nxt_m  = m_ff;

        // two-flop crossings of link level signals
        nxt_m.busy_s1    = l_ff.busy;
        nxt_m.busy_s2    = m_ff.busy_s1;
        nxt_m.refused_s1 = l_ff.refused;
        nxt_m.refused_s2 = m_ff.refused_s1;
        // address pins crossed only to spot a change
        nxt_m.addr_s1    = link_addr;
        nxt_m.addr_s2    = m_ff.addr_s1;
        nxt_m.addr_prev  = m_ff.addr_s2;

        // sleep once the address stays put long enough
        if (m_ff.addr_s2 != m_ff.addr_prev) begin
            nxt_m.stable_cnt = '0;
            nxt_m.sleep      = 1'b0;
        end else if (m_ff.stable_cnt < SLEEP_CNT) begin
            nxt_m.stable_cnt = m_ff.stable_cnt + 1'b1;
        end else begin
            nxt_m.sleep = 1'b1;
        end

        // configuration write, wait states held inside their range
        if (reg_wr && reg_addr == BRW_REG_CFG) begin
            nxt_m.cfg = wcfg;
            if (wcfg.wait_states < BRW_WS_MIN) begin
                nxt_m.cfg.wait_states = BRW_WS_MIN;
            end
        end

        // read data stand for one cycle only
        status[BRW_ST_SLEEP]   = m_ff.sleep;
        status[BRW_ST_BUSY]    = m_ff.busy_s2;
        status[BRW_ST_REFUSED] = m_ff.refused_s2;
        nxt_m.rdata = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                BRW_REG_CFG: begin
                    nxt_m.rdata = BRW_REG_DW'(m_ff.cfg);
                end
                BRW_REG_STATUS: begin
                    nxt_m.rdata = status;
                end
                default: begin
                    nxt_m.rdata = '0;
                end
            endcase
        end
    end

    // register-clock state
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            m_ff <= '{cfg: BRW_CFG_RST, default: '0};
        end else begin
            m_ff <= nxt_m;
        end
    end

    // ------------------------------------------------------------------
    // link clock domain
    // ------------------------------------------------------------------

    // burst engine
    always_comb begin
        logic              give;
        logic [ADDR_W-1:0] next_addr;
        logic [2:0]        next_pos;
        brw_cfg_t          cfg;
        give      = 1'b0;
        next_addr = l_ff.addr;
        next_pos  = l_ff.pos;
        cfg       = l_ff.cfg_s2;
        nxt_l     = l_ff;

        // reset and configuration come in through two flops
        nxt_l.rst_s1 = rst_n;
        nxt_l.rst_s2 = l_ff.rst_s1;
        nxt_l.cfg_s1 = m_ff.cfg;
        nxt_l.cfg_s2 = l_ff.cfg_s1;

        // address order inside or across the 8-word group
        if (cfg.wrap_en) begin
            next_addr = {l_ff.addr[ADDR_W-1:BRW_GROUP_W],
                         BRW_GROUP_W'(l_ff.addr[BRW_GROUP_W-1:0] + 1'b1)};
        end else begin
            next_addr = ADDR_W'(l_ff.addr + 1'b1);
        end
        next_pos = 3'(l_ff.pos + 1'b1);

        unique case (l_ff.st)
            BRW_IDLE: begin
                nxt_l.busy = 1'b0;
            end
            BRW_LATENCY: begin
                // initial wait states count down
                if (l_ff.lat_cnt <= BRW_LAT_LAST) begin
                    nxt_l.st = BRW_BURST;
                end else begin
                    nxt_l.lat_cnt = l_ff.lat_cnt - 1'b1;
                end
            end
            BRW_BURST: begin
                if (l_ff.extra_cnt != '0) begin
                    nxt_l.extra_cnt = l_ff.extra_cnt - 1'b1;
                end else begin
                    give = 1'b1;
                end
            end
        endcase

        // hand a word out and step the address
        if (give) begin
            nxt_l.dq   = array_rdata;
            nxt_l.addr = next_addr;
            // group crossing one to three words after the start
            if (!cfg.wrap_en && next_addr[BRW_GROUP_W-1:0] == '0 &&
                next_pos != '0 && l_ff.pos < 3'h3) begin
                nxt_l.extra_cnt = EXTRA_CNT;
            end
            if (l_ff.pos != BRW_WS_MAX) begin
                nxt_l.pos = next_pos;
            end
        end

        // address strobe: take the address at this edge
        if (!link_ctl.ce_n && !link_ctl.address_valid_strobe_n) begin
            if (cfg.edge_rising) begin
                nxt_l.st        = BRW_LATENCY;
                nxt_l.addr      = link_addr;
                nxt_l.lat_cnt   = cfg.wait_states;
                nxt_l.extra_cnt = '0;
                nxt_l.pos       = '0;
                nxt_l.busy      = 1'b1;
                nxt_l.refused   = 1'b0;
            end else begin
                // falling edge chosen: this end works on rising only
                nxt_l.st      = BRW_IDLE;
                nxt_l.refused = 1'b1;
            end
        end

        // deselect ends the burst
        if (link_ctl.ce_n) begin
            nxt_l.st   = BRW_IDLE;
            nxt_l.busy = 1'b0;
        end

        nxt_l.dq_oe = !link_ctl.ce_n && !link_ctl.oe_n;

        // ready with the word, or one cycle before it
        if (cfg.ready_lead_select) begin
            // a deselect or a fresh strobe in the same cycle kills the word flag
            nxt_l.ready = give && nxt_l.st == BRW_BURST;
        end else begin
            nxt_l.ready = nxt_l.st == BRW_BURST && nxt_l.extra_cnt == '0;
        end

        // synchronised reset clears the engine
        if (!l_ff.rst_s2) begin
            nxt_l.st        = BRW_IDLE;
            nxt_l.lat_cnt   = '0;
            nxt_l.extra_cnt = '0;
            nxt_l.pos       = '0;
            nxt_l.addr      = '0;
            nxt_l.dq        = '0;
            nxt_l.dq_oe     = 1'b0;
            nxt_l.ready     = 1'b0;
            nxt_l.busy      = 1'b0;
            nxt_l.refused   = 1'b0;
        end
    end

    // link-clock state, reset arrives through its own synchroniser
    always_ff @(posedge link_clk) begin
        l_ff <= nxt_l;
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign reg_rdata  = m_ff.rdata;
    assign sleep_o    = m_ff.sleep;
    assign dq_o       = l_ff.dq;
    assign dq_oe      = l_ff.dq_oe;
    assign ready_o    = l_ff.ready;
    assign array_addr = l_ff.addr;

endmodule : brw_burst_read_wait

`default_nettype wire

// *** hw/brw_pkg.sv ***
/*
 * brw_pkg: shared constants and carriers of the burst read wait-state block.
 * Assumes a 100 MHz register clock and a host-supplied link clock.
 */
package brw_pkg;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int BRW_ADDR_W     = 24;   // word address width
    localparam int BRW_DATA_W     = 16;   // data word width
    localparam int BRW_REG_AW     = 4;    // register byte address width
    localparam int BRW_REG_DW     = 32;   // register data width
    localparam int BRW_GROUP_W    = 3;    // log2 of the 8-word burst group
    localparam int BRW_EXTRA_WAIT = 1;    // delay cycles at a group crossing
    localparam int BRW_SLEEP_W    = 8;    // width of the sleep counter

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [BRW_REG_AW-1:0] BRW_REG_CFG    = 4'h0;
    localparam logic [BRW_REG_AW-1:0] BRW_REG_STATUS = 4'h4;

    // status bit positions
    localparam int BRW_ST_SLEEP   = 0;
    localparam int BRW_ST_BUSY    = 1;
    localparam int BRW_ST_REFUSED = 2;

    // wait-state limits
    localparam logic [2:0] BRW_WS_MIN = 3'h2;
    localparam logic [2:0] BRW_WS_MAX = 3'h7;
    localparam logic [2:0] BRW_LAT_LAST = 3'h1;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int BRW_MCLK_PERIOD_NS = 10;
    localparam int BRW_T_ACC_NS       = 80;   // asynchronous access time
    localparam int BRW_T_SLEEP_ADD_NS = 20;   // margin before sleep
    // least time: round up to whole cycles
    localparam int BRW_SLEEP_CYCLES =
        (BRW_T_ACC_NS + BRW_T_SLEEP_ADD_NS + BRW_MCLK_PERIOD_NS - 1) / BRW_MCLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    // configuration word, low bits of the config register
    typedef struct packed {
        logic       edge_rising;        // bit 5: active clock edge is rising
        logic       ready_lead_select;  // bit 4: 0 = ready one cycle ahead
        logic       wrap_en;            // bit 3: wrap inside the 8-word group
        logic [2:0] wait_states;        // bits 2:0: initial wait states
    } brw_cfg_t;

    localparam int       BRW_CFG_W   = $bits(brw_cfg_t);
    localparam brw_cfg_t BRW_CFG_RST = '{edge_rising: 1'b1, ready_lead_select: 1'b1,
                                         wrap_en: 1'b1, wait_states: 3'h7};

    // host control strobes on the link
    typedef struct packed {
        logic ce_n;                    // chip enable
        logic address_valid_strobe_n;  // address strobe
        logic oe_n;                    // output enable
    } brw_ctl_t;

    typedef enum logic [1:0] {
        BRW_IDLE,
        BRW_LATENCY,
        BRW_BURST
    } brw_state_t;

endpackage : brw_pkg

// *** sim/brw_burst_read_wait_checker.sv ***
/* brw_burst_read_wait_checker: port timing of the burst read block.
   Assumes it is bound onto brw_burst_read_wait and sees its ports only. */
`timescale 1ns/10ps
`default_nettype none
module brw_burst_read_wait_checker
    import brw_pkg::*;
#(
    parameter int ADDR_W = BRW_ADDR_W,
    parameter int DATA_W = BRW_DATA_W
) (
    input wire logic                  mclk,
    input wire logic                  rst_n,
    input wire logic [BRW_REG_AW-1:0] reg_addr,
    input wire logic [BRW_REG_DW-1:0] reg_wdata,
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire logic [BRW_REG_DW-1:0] reg_rdata,
    input wire logic                  link_clk,
    input wire brw_ctl_t              link_ctl,
    input wire logic [ADDR_W-1:0]     link_addr,
    input wire logic [DATA_W-1:0]     dq_o,
    input wire logic                  dq_oe,
    input wire logic                  ready_o,
    input wire logic [ADDR_W-1:0]     array_addr,
    input wire logic [DATA_W-1:0]     array_rdata,
    input wire logic                  sleep_o
);
    // ------------------------------------------------------------------
    // link side
    // ------------------------------------------------------------------
    // burst start strobe as seen on the link
    logic stb;
    assign stb = !link_ctl.ce_n && !link_ctl.address_valid_strobe_n;

    chk_addr_capture: assert property (@(posedge link_clk) disable iff (!rst_n)
        stb |=> array_addr == $past(link_addr)) else $error("start address not taken");
    chk_ready_early: assert property (@(posedge link_clk) disable iff (!rst_n)
        stb |=> !ready_o ##1 !ready_o) else $error("ready before two wait states");
    chk_ready_stop: assert property (@(posedge link_clk) disable iff (!rst_n)
        link_ctl.ce_n |=> !ready_o) else $error("ready while deselected");
    chk_dq_drive: assert property (@(posedge link_clk) disable iff (!rst_n)
        (!link_ctl.ce_n && !link_ctl.oe_n) |=> dq_oe) else $error("data not driven");
    chk_dq_release: assert property (@(posedge link_clk) disable iff (!rst_n)
        link_ctl.oe_n |=> !dq_oe) else $error("data driven without enable");
    // ------------------------------------------------------------------
    // register clock side
    // ------------------------------------------------------------------
    chk_sleep_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        $changed(link_addr) |-> ##3 !sleep_o [*8]) else $error("sleep too early");
    chk_sleep_stable: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(sleep_o) |-> link_addr == $past(link_addr, 8)) else $error("sleep on moving address");
    chk_rdata_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
        !reg_rd |=> reg_rdata == '0) else $error("read data outside read slot");
    cov_strobe: cover property (@(posedge link_clk) disable iff (!rst_n) stb);
    cov_ready: cover property (@(posedge link_clk) disable iff (!rst_n) $rose(ready_o));
    cov_sleep: cover property (@(posedge mclk) disable iff (!rst_n) $rose(sleep_o));
endmodule : brw_burst_read_wait_checker

bind brw_burst_read_wait brw_burst_read_wait_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
    brw_burst_read_wait_checker_inst (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .link_clk(link_clk), .link_ctl(link_ctl), .link_addr(link_addr), .dq_o(dq_o),
    .dq_oe(dq_oe), .ready_o(ready_o), .array_addr(array_addr),
    .array_rdata(array_rdata), .sleep_o(sleep_o));
`default_nettype wire

// *** sim/brw_burst_read_wait_tb.sv ***
/* brw_burst_read_wait_tb: register and burst scenarios for the block.
   Assumes brw_host plays the host controller and the storage array. */
`timescale 1ns/10ps
`default_nettype none
module brw_burst_read_wait_tb
    import brw_pkg::*;
;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        lead_mode = 1'b1;
    logic [31:0] reg_rdata, rv;
    logic        link_clk, dq_oe, ready_o, sleep_o;
    brw_ctl_t    link_ctl;
    logic [23:0] link_addr, array_addr;
    logic [15:0] dq_o, array_rdata;
    int          n_fail = 0;
    int          check_count = 0;
    // register clock
    always #5 mclk = ~mclk;

    brw_burst_read_wait brw_burst_read_wait_inst (.mclk(mclk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .link_clk(link_clk), .link_ctl(link_ctl),
        .link_addr(link_addr), .dq_o(dq_o), .dq_oe(dq_oe), .ready_o(ready_o),
        .array_addr(array_addr), .array_rdata(array_rdata), .sleep_o(sleep_o));
    brw_host brw_host_inst (.link_clk(link_clk), .link_ctl(link_ctl),
        .link_addr(link_addr), .array_rdata(array_rdata), .array_addr(array_addr),
        .dq_o(dq_o), .ready_o(ready_o), .lead_mode(lead_mode));
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask : rd
    // configure, run an 8-word burst, compare words and arrival edges
    task automatic run_burst(input logic [5:0] cfg, input logic [23:0] a,
                             input int ws, input int xtra);
        logic [23:0] p;
        wr(BRW_REG_CFG, {26'h0, cfg});
        brw_host_inst.burst(a, 8);
        check(32'(brw_host_inst.got.size()), 32'h8);
        for (int i = 0; i < brw_host_inst.got.size(); i++) begin
            p = cfg[3] ? {a[23:3], a[2:0] + 3'(i)} : a + 24'(i);
            check({16'h0, brw_host_inst.got[i]}, {16'h0, p[15:0] ^ 16'h5a00});
            check(32'(brw_host_inst.gotk[i]), 32'(ws + 1 + i + (i >= 3 ? xtra : 0)));
        end
    endtask : run_burst
    task automatic close_out;
        if (n_fail == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial begin
        repeat (2) @(posedge mclk);
        repeat (4) @(posedge link_clk);
        @(posedge mclk);
        rst_n <= 1'b1;
        rd(BRW_REG_CFG, rv);
        check(rv, 32'h3f);
        rd(4'h8, rv);
        check(rv, 32'h0);
        wr(BRW_REG_STATUS, 32'h7);
        run_burst(6'h38, 24'h1d, 2, 0);
        rd(BRW_REG_CFG, rv);
        check(rv, 32'h3a);
        run_burst(6'h37, 24'h1d, 7, BRW_EXTRA_WAIT);
        lead_mode = 1'b0;
        run_burst(6'h2e, 24'h40, 6, 0);
        for (int i = 0; i < 200 && sleep_o !== 1'b1; i++)
            @(negedge mclk);
        check({31'h0, sleep_o}, 32'h1);
        rd(BRW_REG_STATUS, rv);
        check(rv, 32'h1);
        close_out();
    end
endmodule : brw_burst_read_wait_tb
`default_nettype wire

// *** sim/brw_host.sv ***
/* brw_host: host controller and storage array at the far side of the link.
   Assumes the bench calls burst() and sets lead_mode to the ready timing. */
`timescale 1ns/10ps
`default_nettype none
module brw_host
    import brw_pkg::*;
(
    output var logic        link_clk,
    output var brw_ctl_t    link_ctl,
    output var logic [23:0] link_addr,
    output logic     [15:0] array_rdata,
    input  wire logic [23:0] array_addr,
    input  wire logic [15:0] dq_o,
    input  wire logic        ready_o,
    input  wire logic        lead_mode
);
    logic        run = 1'b1;
    logic [15:0] got[$];
    int          gotk[$];
    // storage word pattern
    assign array_rdata = array_addr[15:0] ^ 16'h5a00;
    // burst clock, stood still between frames
    initial begin
        link_clk = 1'b0;
        link_ctl = 3'b111;
        link_addr = 24'h0;
        #37;
        forever begin
            #80;
            if (run)
                link_clk = ~link_clk;
        end
    end
    // one burst of n words, k counts link edges after the start edge
    task automatic burst(input logic [23:0] a, input int n);
        int   k;
        logic rq;
        k = 0;
        rq = 1'b0;
        got.delete();
        gotk.delete();
        run = 1'b1;
        repeat (3) @(posedge link_clk);
        link_addr <= a;
        link_ctl <= 3'b000;
        @(posedge link_clk);
        link_ctl <= 3'b010;
        link_addr <= ~a;            // address released
        while (got.size() < n && k < 40) begin
            @(negedge link_clk);
            if (lead_mode ? ready_o : rq) begin
                got.push_back(dq_o);
                gotk.push_back(k);
            end
            rq = ready_o;
            k++;
        end
        @(posedge link_clk);
        link_ctl <= 3'b111;
        repeat (2) @(posedge link_clk);
        run = 1'b0;
    endtask : burst
endmodule : brw_host
`default_nettype wire
